// ==== dv/fas_seq_monitor.sv ====
// checker: port timing of the output sequencer
`timescale 1ns/10ps
`default_nettype none
module fas_seq_monitor
  import fas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic conv_clk_i,
  input wire logic out_en_i,
  input wire logic out_en_n_i,
  input wire logic out_en_open_i,
  input wire logic out_en_n_open_i,
  input wire logic [fas_pkg::DATA_W-1:0] conversion_result_o,
  input wire logic conversion_result_oe_n_o,
  input wire logic overrange_flag_o,
  input wire logic reg_rd_i,
  input wire logic [fas_pkg::REG_W-1:0] reg_rdata_o
);
  logic conv_q_r;
  logic [3:0] fcnt_r;
  wire logic en_ok = (out_en_i | out_en_open_i) &
                     ~(out_en_n_i | out_en_n_open_i);
  wire logic fall_seen = conv_q_r & ~conv_clk_i;
  // cycles since the conversion clock pin fell
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_q_r <= 1'b0;
      fcnt_r <= 4'hf;
    end else begin
      conv_q_r <= conv_clk_i;
      fcnt_r <= fall_seen ? 4'h0 : fcnt_r + {3'h0, ~&fcnt_r};
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_high; conv_clk_i [*3]; endsequence
  sequence s_on; en_ok [*4]; endsequence
  sequence s_off; !en_ok [*4]; endsequence
  property p_hold_high; s_high |-> $stable(conversion_result_o); endproperty
  property p_ovr_high; s_high |-> $stable(overrange_flag_o); endproperty
  property p_drive_on; s_on |-> !conversion_result_oe_n_o; endproperty
  property p_drive_off; s_off |-> conversion_result_oe_n_o; endproperty
  property p_data_win;
    $changed(conversion_result_o) |-> fcnt_r inside {[3:7]};
  endproperty
  property p_ovr_win;
    $changed(overrange_flag_o) |-> fcnt_r inside {[3:7]};
  endproperty
  property p_ovr_en; s_off ##0 s_high |-> $stable(overrange_flag_o); endproperty
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == '0; endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("data moved with clock high");
  a_ovr_high: assert property (p_ovr_high)
    else $error("overrange moved with clock high");
  a_drive_on: assert property (p_drive_on)
    else $error("data not driven");
  a_drive_off: assert property (p_drive_off)
    else $error("data driven while disabled");
  a_data_win: assert property (p_data_win)
    else $error("data changed outside fall window");
  a_ovr_win: assert property (p_ovr_win)
    else $error("overrange changed outside fall window");
  a_ovr_en: assert property (p_ovr_en)
    else $error("overrange moved while disabled");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without read");
endmodule // fas_seq_monitor
`default_nettype wire

// ==== dv/fas_sequencer_test.sv ====
// testbench: random samples, enables and register checks
`timescale 1ns/10ps
`default_nettype none
module fas_sequencer_test;
  import fas_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [COMP_NUM-1:0] comp = '0;
  logic [3:0] en = 4'h0;
  logic [7:0] addr = 8'h00, res;
  logic [31:0] wdata = '0, rdata, d, seed = 32'd46096;
  logic wr = 1'b0, rd = 1'b0, run = 1'b0, conv_clk, oe_n, overrange_flag, irq, exp_oe;
  logic [8:0] exp_v = 9'h000, cap;
  int fail_count = 0, compares = 0, cyc = 0, lvl, rises = 0;
  int corner[4] = '{0, 256, 255, 1};
  always #4 ref_clk_i = ~ref_clk_i;
  fas_sys_model sys (.ref_clk_i, .run_i(run), .data_i(res),
    .data_oe_n_i(oe_n), .overrange_i(overrange_flag), .conv_clk_o(conv_clk),
    .cap_o(cap));
  fas_sequencer dut (.ref_clk_i, .sys_rst_i, .conv_clk_i(conv_clk),
    .comparator_i(comp), .out_en_i(en[3]), .out_en_n_i(en[2]),
    .out_en_open_i(en[1]), .out_en_n_open_i(en[0]),
    .conversion_result_o(res), .conversion_result_oe_n_o(oe_n),
    .overrange_flag_o(overrange_flag), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq));
  function logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function logic [8:0] expect_of(input int l);
    return {l > 255, (l > 255) ? 8'hff : 8'(l)};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task test_done;
    if (fail_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      test_done;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    run <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge conv_clk);
      @(posedge ref_clk_i);
      if (i > 0) begin
        chk({23'h0, overrange_flag, res}, {23'h0, exp_v});
        chk({23'h0, cap},
            {23'h0, exp_v[8], exp_oe ? 8'hff : exp_v[7:0]});
        chk({31'h0, oe_n}, {31'h0, exp_oe});
      end
      seed = xs(seed);
      lvl = (i < 4) ? corner[i] : int'(seed % 32'd257);
      comp <= (lvl > 255) ? '1 : (256'd1 << lvl) - 256'd1;
      en <= seed[11:8];
      if (expect_of(lvl) > 9'h0ff && !exp_v[8]) begin
        rises++;
      end
      exp_v = expect_of(lvl);
      exp_oe = ~((seed[11] | seed[9]) & ~(seed[10] | seed[8]));
    end
    @(posedge ref_clk_i);
    run <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rd_reg(RESULT_OFS);
    chk(d, {23'h0, exp_v});
    rd_reg(SAMPLE_CNT_OFS);
    chk(d, 32'h28);
    rd_reg(OVR_CNT_OFS);
    chk(d, 32'(rises));
    rd_reg(PIN_STATE_OFS);
    chk(d, {24'h0, SEQ_SHOW, 1'b0, seed[11] | seed[9],
      seed[10] | seed[8], ~exp_oe});
    wr_reg(MASK_OFS, 32'h0);
    rd_reg(STATUS_OFS);
    chk(d & 32'h3, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr_reg(MASK_OFS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    #1 chk({31'h0, irq}, 32'h1);
    wr_reg(STATUS_OFS, 32'h7);
    repeat (2) @(posedge ref_clk_i);
    #1 chk({31'h0, irq}, 32'h0);
    rd_reg(STATUS_OFS);
    chk(d, 32'h0);
    rd_reg(8'h30);
    chk(d, 32'h0);
    test_done;
  end
endmodule // fas_sequencer_test
bind fas_sequencer fas_seq_monitor u_mon (.ref_clk_i, .sys_rst_i,
  .conv_clk_i, .out_en_i, .out_en_n_i, .out_en_open_i, .out_en_n_open_i,
  .conversion_result_o, .conversion_result_oe_n_o, .overrange_flag_o,
  .reg_rd_i, .reg_rdata_o);
`default_nettype wire

// ==== dv/fas_sys_model.sv ====
// partner: system logic making the conversion clock, capturing data
`timescale 1ns/10ps
`default_nettype none
module fas_sys_model #(
  parameter int HI_CYC = 4,
  parameter int LO_CYC = 8
) (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_n_i,
  input wire logic overrange_i,
  output logic conv_clk_o,
  output logic [8:0] cap_o
);
  int cnt = 0;
  logic clk_r = 1'b0;
  logic [8:0] cap_r = 9'h000;
  // released data lines float up to the pull-up level
  wire logic [7:0] bus_w = data_oe_n_i ? 8'hff : data_i;
  assign conv_clk_o = clk_r;
  assign cap_o = cap_r;
  // widths never below three cycles
  always @(posedge ref_clk_i) begin
    if (!run_i) begin
      clk_r <= 1'b0;
      cnt <= 0;
    end else if (cnt == (clk_r ? HI_CYC : LO_CYC) - 1) begin
      clk_r <= ~clk_r;
      cnt <= 0;
      if (!clk_r) begin
        cap_r <= {overrange_i, bus_w};
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // fas_sys_model
`default_nettype wire

// ==== hw/fas_gray_to_bin.sv ====
// gray code to natural binary translation
`timescale 1ns/10ps
`default_nettype none
module fas_gray_to_bin #(
  parameter int W = 8
) (
  input wire logic [W-1:0] gray_i,
  output logic [W-1:0] bin_o
);
  // each binary bit is the xor of all gray bits at and above it
  always_comb begin
    bin_o[W-1] = gray_i[W-1];
    for (int i = W - 2; i >= 0; i--) begin
      bin_o[i] = bin_o[i+1] ^ gray_i[i];
    end
  end
endmodule // fas_gray_to_bin
`default_nettype wire

// ==== hw/fas_pkg.sv ====
// package: constants for the flash converter output sequencer
package fas_pkg;
  // comparator bank and output word
  localparam int COMP_NUM = 256;
  localparam int DATA_W = 8;
  localparam int OVR_IDX = 255;
  localparam logic [7:0] CODE_MAX = 8'hff;
  // timing, clock in ns
  localparam int CLK_PERIOD_NS = 8;
  localparam int DATA_VALID_NS = 20;
  localparam int CONV_CYC_RAW = DATA_VALID_NS / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam logic [3:0] CONV_CNT_LOAD = 4'(CONV_CYC);
  // register bus
  localparam int ADDR_W = 8;
  localparam int REG_W = 32;
  localparam logic [7:0] RESULT_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] SAMPLE_CNT_OFS = 8'h0c;
  localparam logic [7:0] OVR_CNT_OFS = 8'h10;
  localparam logic [7:0] PIN_STATE_OFS = 8'h14;
  // event bit positions in status and mask
  localparam int EV_W = 3;
  localparam int EV_SAMPLE = 0;
  localparam int EV_OVR_RISE = 1;
  localparam int EV_DRIVE_CHG = 2;
  // reset values
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // field position of overrange in result register
  localparam int RESULT_OVR_BIT = 8;
  // sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_TRACK = 4'b0010,
    SEQ_CONVERT = 4'b0100,
    SEQ_SHOW = 4'b1000
  } fas_seq_t;
endpackage : fas_pkg

// ==== hw/fas_sequencer.sv ====
// flash converter digital side: sample, encode, latch, drive
`timescale 1ns/10ps
`default_nettype none
module fas_sequencer
  import fas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // conversion clock pin from the system
  input wire logic conv_clk_i,
  // comparator outputs, index 0 is the lowest threshold
  input wire logic [fas_pkg::COMP_NUM-1:0] comparator_i,
  // output enables and their open-pin indications
  input wire logic out_en_i,
  input wire logic out_en_n_i,
  input wire logic out_en_open_i,
  input wire logic out_en_n_open_i,
  // converted word and overrange
  output logic [fas_pkg::DATA_W-1:0] conversion_result_o,
  output logic conversion_result_oe_n_o,
  output logic overrange_flag_o,
  // register port
  input wire logic [fas_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [fas_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [fas_pkg::REG_W-1:0] reg_rdata_o,
  // interrupt
  output logic irq_o
);
  import fas_pkg::*;

  // popcount of the in-range comparators
  function automatic logic [8:0] count_ones(
    input logic [COMP_NUM-2:0] v
  );
    logic [8:0] acc;
    acc = 9'h000;
    for (int i = 0; i < COMP_NUM - 1; i++) begin
      acc = acc + {8'h00, v[i]};
    end
    return acc;
  endfunction

  // binary to gray
  function automatic logic [7:0] to_gray(input logic [7:0] b);
    return b ^ {1'b0, b[7:1]};
  endfunction

  // two flop synchronisers for pins
  logic clk_s1_r;
  logic clk_s2_r;
  logic clk_d_r;
  logic [COMP_NUM-1:0] comp_s1_r;
  logic [COMP_NUM-1:0] comp_s2_r;
  logic [3:0] en_s1_r;
  logic [3:0] en_s2_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_d_r <= 1'b0;
    end else begin
      clk_s1_r <= conv_clk_i;
      clk_s2_r <= clk_s1_r;
      clk_d_r <= clk_s2_r;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      comp_s1_r <= '0;
      comp_s2_r <= '0;
    end else begin
      comp_s1_r <= comparator_i;
      comp_s2_r <= comp_s1_r;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_s1_r <= 4'h0;
      en_s2_r <= 4'h0;
    end else begin
      en_s1_r <= {out_en_i, out_en_n_i, out_en_open_i, out_en_n_open_i};
      en_s2_r <= en_s1_r;
    end
  end

  // edges of the conversion clock
  wire clk_rise = clk_s2_r & ~clk_d_r;
  wire clk_fall = ~clk_s2_r & clk_d_r;

  // sequencer state
  fas_seq_t seq_r;
  fas_seq_t seq_nxt;
  logic [3:0] conv_cnt_r;
  logic [3:0] conv_cnt_nxt;
  logic [COMP_NUM-1:0] comp_latch_r;
  logic [7:0] gray_r;
  logic ovr_hold_r;
  logic [7:0] result_r;
  logic ovr_r;
  wire [7:0] bin_w;

  always_comb begin
    seq_nxt = seq_r;
    conv_cnt_nxt = conv_cnt_r;
    case (seq_r)
      SEQ_IDLE: begin
        if (clk_rise) begin
          seq_nxt = SEQ_TRACK;
        end
      end
      SEQ_TRACK: begin
        if (clk_fall) begin
          seq_nxt = SEQ_CONVERT;
          conv_cnt_nxt = CONV_CNT_LOAD - 4'h1;
        end
      end
      SEQ_CONVERT: begin
        if (conv_cnt_r == 4'h1) begin
          seq_nxt = SEQ_SHOW;
          conv_cnt_nxt = 4'h0;
        end else begin
          conv_cnt_nxt = conv_cnt_r - 4'h1;
        end
      end
      SEQ_SHOW: begin
        if (clk_rise) begin
          seq_nxt = SEQ_TRACK;
        end
      end
      default: begin
        seq_nxt = SEQ_IDLE;
        conv_cnt_nxt = 4'h0;
      end
    endcase
  end

  // comparators follow the input only while the clock is high
  wire comp_track = clk_s2_r;
  // thresholds below the top one give the code, saturating
  wire [8:0] comp_count = count_ones(comp_latch_r[COMP_NUM-2:0]);
  wire [7:0] code_sat = (comp_count > {1'b0, CODE_MAX}) ?
                        CODE_MAX : comp_count[7:0];
  wire conv_start = (seq_r == SEQ_TRACK) && clk_fall;
  wire conv_done = (seq_r == SEQ_CONVERT) && (conv_cnt_r == 4'h1);

  fas_gray_to_bin #(
    .W(DATA_W)
  ) u_gray_to_bin (
    .gray_i(gray_r),
    .bin_o(bin_w)
  );

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_r <= SEQ_IDLE;
      conv_cnt_r <= 4'h0;
    end else begin
      seq_r <= seq_nxt;
      conv_cnt_r <= conv_cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      comp_latch_r <= '0;
    end else begin
      if (comp_track) begin
        comp_latch_r <= comp_s2_r;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gray_r <= 8'h00;
      ovr_hold_r <= 1'b0;
    end else begin
      if (conv_start) begin
        gray_r <= to_gray(code_sat);
        ovr_hold_r <= comp_latch_r[OVR_IDX];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_r <= RESULT_RST;
      ovr_r <= 1'b0;
    end else begin
      if (conv_done) begin
        result_r <= bin_w;
        ovr_r <= ovr_hold_r;
      end
    end
  end

  // enables: open pins read as one, drive only for 1 and 0
  wire en_lvl = en_s2_r[3] | en_s2_r[1];
  wire en_n_lvl = en_s2_r[2] | en_s2_r[0];
  wire drive_w = en_lvl & ~en_n_lvl;

  // output register stage
  logic drive_r;
  logic oe_n_r;
  logic [7:0] out_r;
  logic ovr_out_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_r <= 1'b0;
      oe_n_r <= 1'b1;
      out_r <= RESULT_RST;
      ovr_out_r <= 1'b0;
    end else begin
      drive_r <= drive_w;
      oe_n_r <= ~drive_w;
      out_r <= result_r;
      ovr_out_r <= ovr_r;
    end
  end

  assign conversion_result_o = out_r;
  assign conversion_result_oe_n_o = oe_n_r;
  assign overrange_flag_o = ovr_out_r;

  // events
  logic ovr_prev_r;
  logic drive_prev_r;
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_SAMPLE] = conv_done;
  assign ev_set[EV_OVR_RISE] = ovr_r & ~ovr_prev_r;
  assign ev_set[EV_DRIVE_CHG] = drive_r ^ drive_prev_r;

  // register decode
  wire sel_result = reg_addr_i == RESULT_OFS;
  wire sel_status = reg_addr_i == STATUS_OFS;
  wire sel_mask = reg_addr_i == MASK_OFS;
  wire sel_smp_cnt = reg_addr_i == SAMPLE_CNT_OFS;
  wire sel_ovr_cnt = reg_addr_i == OVR_CNT_OFS;
  wire sel_pins = reg_addr_i == PIN_STATE_OFS;

  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] status_nxt;
  logic [EV_W-1:0] mask_r;
  logic [15:0] smp_cnt_r;
  logic [15:0] ovr_cnt_r;
  logic [REG_W-1:0] rdata_r;
  logic [REG_W-1:0] rdata_nxt;
  logic irq_r;

  // write one to clear, a new event wins over the clear
  wire [EV_W-1:0] status_clr = (reg_wr_i && sel_status) ?
                               reg_wdata_i[EV_W-1:0] : '0;
  assign status_nxt = (status_r & ~status_clr) | ev_set;

  always_comb begin
    rdata_nxt = '0;
    if (reg_rd_i) begin
      if (sel_result) begin
        rdata_nxt[7:0] = result_r;
        rdata_nxt[RESULT_OVR_BIT] = ovr_r;
      end else if (sel_status) begin
        rdata_nxt[EV_W-1:0] = status_r;
      end else if (sel_mask) begin
        rdata_nxt[EV_W-1:0] = mask_r;
      end else if (sel_smp_cnt) begin
        rdata_nxt[15:0] = smp_cnt_r;
      end else if (sel_ovr_cnt) begin
        rdata_nxt[15:0] = ovr_cnt_r;
      end else if (sel_pins) begin
        rdata_nxt[3:0] = {clk_s2_r, en_lvl, en_n_lvl, drive_r};
        rdata_nxt[7:4] = seq_r;
      end else begin
        rdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_r <= STATUS_RST;
      mask_r <= MASK_RST;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (reg_wr_i && sel_mask) begin
        mask_r <= reg_wdata_i[EV_W-1:0];
      end
      irq_r <= |(status_nxt & mask_r);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smp_cnt_r <= CNT_RST;
      ovr_cnt_r <= CNT_RST;
    end else begin
      if (conv_done) begin
        smp_cnt_r <= smp_cnt_r + 16'h0001;
      end
      if (ev_set[EV_OVR_RISE]) begin
        ovr_cnt_r <= ovr_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovr_prev_r <= 1'b0;
      drive_prev_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ovr_prev_r <= ovr_r;
      drive_prev_r <= drive_r;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o = irq_r;

endmodule // fas_sequencer
`default_nettype wire
